// ===== hw/gif_core.sv
// What this block does
// - Force words 0x110, 0x114, 0x118, 0x11c raise their events regardless.
// - Read-only status word 0x120 shows events after enable and force.
// - Four bits a pin, rise/fall/high/low downward, highest pin on top.
// - Every force bit reads back as written and clears to zero on reset.
// - Force word 3 holds pins 24 to 29; its top byte forces nothing.
// - Status word covers pins 0 to 7, ignores writes, resets to zero.
// - Enable bits of the same layout gate raw events before status.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module gif_core (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Register port
  input wire gif_pkg::gif_bus_req_t bus_req,
  output logic [gif_pkg::GIF_DW-1:0] rdata,
  // Raw pin events, pin p at bits 4p+3..4p
  input wire gif_pkg::gif_evvec_t raw_events,
  // Interrupt lines
  output logic first_core_irq,
  output logic house_irq
);
  import gif_pkg::*;

  function automatic logic addr_is(input logic [GIF_AW-1:0] a,
                                   input logic [GIF_AW-1:0] off);
    addr_is = (a == off);
  endfunction : addr_is

  logic [GIF_DW-1:0] en0_reg;
  logic [GIF_DW-1:0] en1_reg;
  logic [GIF_DW-1:0] en2_reg;
  logic [GIF_FRC3_W-1:0] en3_reg;
  logic [GIF_DW-1:0] frc0_reg;
  logic [GIF_DW-1:0] frc1_reg;
  logic [GIF_DW-1:0] frc2_reg;
  logic [GIF_FRC3_W-1:0] frc3_reg;
  logic [GIF_DW-1:0] rdata_reg;
  logic [GIF_DW-1:0] rdata_next;
  logic irq_reg;
  logic [GIF_EV_N-1:0] ev_reg;
  logic [GIF_EV_N-1:0] ev_next;
  logic [GIF_EV_N-1:0] ev_mask_reg;

  // Address decode
  wire hit_en0 = addr_is(bus_req.addr, GIF_OFF_EN0);
  wire hit_en1 = addr_is(bus_req.addr, GIF_OFF_EN1);
  wire hit_en2 = addr_is(bus_req.addr, GIF_OFF_EN2);
  wire hit_en3 = addr_is(bus_req.addr, GIF_OFF_EN3);
  wire hit_frc0 = addr_is(bus_req.addr, GIF_OFF_FRC0);
  wire hit_frc1 = addr_is(bus_req.addr, GIF_OFF_FRC1);
  wire hit_frc2 = addr_is(bus_req.addr, GIF_OFF_FRC2);
  wire hit_frc3 = addr_is(bus_req.addr, GIF_OFF_FRC3);
  wire hit_sts0 = addr_is(bus_req.addr, GIF_OFF_STS0);
  wire hit_ev = addr_is(bus_req.addr, GIF_OFF_EVT);
  wire hit_evm = addr_is(bus_req.addr, GIF_OFF_EVT_MASK);
  wire hit_any = hit_en0 | hit_en1 | hit_en2 | hit_en3 | hit_frc0
               | hit_frc1 | hit_frc2 | hit_frc3 | hit_sts0 | hit_ev
               | hit_evm;
  wire acc = bus_req.wr | bus_req.rd;
  wire wr_ev = bus_req.wr & hit_ev;

  // Flattened enable and force vectors, pin 0 at the bottom
  wire gif_evvec_t en_all = {en3_reg, en2_reg, en1_reg, en0_reg};
  wire gif_evvec_t frc_all = {frc3_reg, frc2_reg, frc1_reg, frc0_reg};
  wire gif_evvec_t status_all;

  // Per pin: each event type raw AND enable OR force
  for (genvar p = 0; p < GIF_PINS; p++) begin : g_pin
    wire [GIF_LANE-1:0] raw_l = raw_events[p*GIF_LANE +: GIF_LANE];
    wire [GIF_LANE-1:0] en_l = en_all[p*GIF_LANE +: GIF_LANE];
    wire [GIF_LANE-1:0] frc_l = frc_all[p*GIF_LANE +: GIF_LANE];
    assign status_all[p*GIF_LANE +: GIF_LANE] =
      (raw_l & en_l) | frc_l;
  end

  wire [GIF_DW-1:0] status_word0 = status_all[GIF_DW-1:0];
  wire any_status = |status_all;
  wire frc3_rsvd_wr = bus_req.wr & hit_frc3
                    & (|(bus_req.wdata & ~GIF_FRC3_MASK));

  // Read mux; reserved and unmapped read as zero
  wire [GIF_DW-1:0] frc3_word = {{(GIF_DW-GIF_FRC3_W){1'b0}}, frc3_reg};
  wire [GIF_DW-1:0] en3_word = {{(GIF_DW-GIF_FRC3_W){1'b0}}, en3_reg};
  wire [GIF_DW-1:0] ev_word = {{(GIF_DW-GIF_EV_N){1'b0}}, ev_reg};
  wire [GIF_DW-1:0] evm_word = {{(GIF_DW-GIF_EV_N){1'b0}}, ev_mask_reg};
  wire [GIF_DW-1:0] rd_mux =
      ({GIF_DW{hit_en0}} & en0_reg)
    | ({GIF_DW{hit_en1}} & en1_reg)
    | ({GIF_DW{hit_en2}} & en2_reg)
    | ({GIF_DW{hit_en3}} & en3_word)
    | ({GIF_DW{hit_frc0}} & frc0_reg)
    | ({GIF_DW{hit_frc1}} & frc1_reg)
    | ({GIF_DW{hit_frc2}} & frc2_reg)
    | ({GIF_DW{hit_frc3}} & frc3_word)
    | ({GIF_DW{hit_sts0}} & status_word0)
    | ({GIF_DW{hit_ev}} & ev_word)
    | ({GIF_DW{hit_evm}} & evm_word);
  assign rdata_next = bus_req.rd ? rd_mux : GIF_RST_WORD;

  // Sticky events: a new event beats a same-cycle clear
  wire [GIF_EV_N-1:0] ev_set = {acc & ~hit_any, frc3_rsvd_wr,
                                any_status & ~irq_reg};
  wire [GIF_EV_N-1:0] ev_clr = wr_ev ? bus_req.wdata[GIF_EV_N-1:0]
                                     : GIF_RST_EV;
  assign ev_next = ev_set | (ev_reg & ~ev_clr);

  // Enable registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      en0_reg <= GIF_RST_WORD;
      en1_reg <= GIF_RST_WORD;
      en2_reg <= GIF_RST_WORD;
      en3_reg <= GIF_RST_FRC3;
    end else if (bus_req.wr) begin
      if (hit_en0) en0_reg <= bus_req.wdata;
      if (hit_en1) en1_reg <= bus_req.wdata;
      if (hit_en2) en2_reg <= bus_req.wdata;
      if (hit_en3) en3_reg <= bus_req.wdata[GIF_FRC3_W-1:0];
    end
  end

  // Force registers; status word has no write path
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      frc0_reg <= GIF_RST_WORD;
      frc1_reg <= GIF_RST_WORD;
      frc2_reg <= GIF_RST_WORD;
      frc3_reg <= GIF_RST_FRC3;
    end else if (bus_req.wr) begin
      if (hit_frc0) frc0_reg <= bus_req.wdata;
      if (hit_frc1) frc1_reg <= bus_req.wdata;
      if (hit_frc2) frc2_reg <= bus_req.wdata;
      if (hit_frc3) frc3_reg <= bus_req.wdata[GIF_FRC3_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata_reg <= GIF_RST_WORD;
      irq_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      irq_reg <= any_status;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ev_reg <= GIF_RST_EV;
      ev_mask_reg <= GIF_RST_EV;
    end else begin
      ev_reg <= ev_next;
      if (bus_req.wr && hit_evm) begin
        ev_mask_reg <= bus_req.wdata[GIF_EV_N-1:0];
      end
    end
  end

  assign rdata = rdata_reg;
  assign first_core_irq = irq_reg;
  assign house_irq = |(ev_reg & ev_mask_reg);

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  force_write_a: assert property (
    bus_req.wr && hit_frc1
    |=> frc1_reg == $past(bus_req.wdata))
    else $error("force word did not take the write");

  force_effect_a: assert property (
    (frc2_reg != GIF_RST_WORD)
    |-> ##1 first_core_irq)
    else $error("forced event did not raise the core line");

  status_read_a: assert property (
    bus_req.rd && hit_sts0
    |=> rdata == $past(status_word0))
    else $error("status read returned the wrong word");

  pin7_rise_a: assert property (
    bus_req.rd && hit_sts0 && raw_events[31] && en0_reg[31]
    |=> rdata[31])
    else $error("pin 7 rising event not in the top bit");

  after_reset_a: assert property (
    $past(srst)
    |-> frc0_reg == GIF_RST_WORD && frc1_reg == GIF_RST_WORD
        && frc3_reg == GIF_RST_FRC3 && rdata == GIF_RST_WORD)
    else $error("force bits or read data not clear after reset");

  reserved_top_a: assert property (
    bus_req.rd && hit_frc3
    |=> rdata[GIF_DW-1:GIF_FRC3_W] == 8'h00)
    else $error("reserved force bits read nonzero");

  status_ro_a: assert property (
    bus_req.wr && hit_sts0
    |=> $stable(frc0_reg) && $stable(en0_reg) && $stable(frc1_reg))
    else $error("write to status word changed state");

  enable_gate_a: assert property (
    en_all == '0 && frc_all == '0
    |=> !first_core_irq)
    else $error("masked event reached the core line");

  core_line_a: assert property (
    any_status[*2] |-> ##1 first_core_irq ##0 $past(first_core_irq))
    else $error("core line low while status bits set");

  core_drop_a: assert property (
    !any_status |=> !first_core_irq)
    else $error("core line high with no status bit");

  set_wins_a: assert property (
    wr_ev && bus_req.wdata[GIF_EV_IRQ_RISE] && any_status && !irq_reg
    |=> ev_reg[GIF_EV_IRQ_RISE])
    else $error("event lost against its clear");

  force_low_a: assert property (
    bus_req.wr && hit_frc2
    |=> frc2_reg == $past(bus_req.wdata))
    else $error("force word 2 did not take the write");

  force_top_a: assert property (
    bus_req.wr && hit_frc3
    |=> frc3_reg == $past(bus_req.wdata[GIF_FRC3_W-1:0]))
    else $error("force word 3 lanes did not take the write");

  rsvd_flag_a: assert property (
    frc3_rsvd_wr
    |=> ev_reg[GIF_EV_RSVD_WR])
    else $error("reserved force write not flagged");

  status_clear_a: assert property (
    $past(srst)
    |-> status_word0 == GIF_RST_WORD)
    else $error("status word not zero after reset");

  read_idle_a: assert property (
    !bus_req.rd
    |=> rdata == GIF_RST_WORD)
    else $error("read data not zero outside a read");

  enable_write_a: assert property (
    bus_req.wr && hit_en0
    |=> en0_reg == $past(bus_req.wdata))
    else $error("enable word did not take the write");

  force_base_a: assert property (
    bus_req.wr && hit_frc0
    |=> frc0_reg == $past(bus_req.wdata))
    else $error("force word 0 did not take the write");

  force_lane_a: assert property (
    bus_req.rd && hit_sts0 && frc0_reg[GIF_LANE+GIF_BIT_LOW]
    |=> rdata[GIF_LANE+GIF_BIT_LOW])
    else $error("forced pin 1 low event not in its lane");

  unmapped_flag_a: assert property (
    acc && !hit_any
    |=> ev_reg[GIF_EV_UNMAPPED])
    else $error("unmapped access not flagged");

  unmapped_read_a: assert property (
    bus_req.rd && !hit_any
    |=> rdata == GIF_RST_WORD)
    else $error("unmapped read returned data");

  line_flag_a: assert property (
    any_status && !first_core_irq
    |=> ev_reg[GIF_EV_IRQ_RISE])
    else $error("core line rise not flagged");

  flag_clear_a: assert property (
    wr_ev && bus_req.wdata[GIF_EV_UNMAPPED]
    |=> !ev_reg[GIF_EV_UNMAPPED])
    else $error("event bit not cleared by a one");

  mask_write_a: assert property (
    bus_req.wr && hit_evm
    |=> ev_mask_reg == $past(bus_req.wdata[GIF_EV_N-1:0]))
    else $error("event mask did not take the write");

  set_wins_c: cover property (
    wr_ev && bus_req.wdata[GIF_EV_IRQ_RISE] && any_status && !irq_reg);

  line_drop_c: cover property (
    first_core_irq ##1 !first_core_irq);

  forced_irq_c: cover property (
    bus_req.wr && hit_frc1 && bus_req.wdata != GIF_RST_WORD
    ##2 first_core_irq);

  status_read_c: cover property (
    bus_req.rd && hit_sts0 ##1 rdata != GIF_RST_WORD);

  house_irq_c: cover property (
    acc && !hit_any ##1 ev_mask_reg[GIF_EV_UNMAPPED] ##1 house_irq);

endmodule : gif_core
`default_nettype wire

// ===== pkg/gif_pkg.sv
`default_nettype none
package gif_pkg;
  // Bus geometry
  localparam int unsigned GIF_AW = 12;
  localparam int unsigned GIF_DW = 32;
  // Pin bank geometry: four event bits per pin, eight pins a word
  localparam int unsigned GIF_PINS = 30;
  localparam int unsigned GIF_LANE = 4;
  localparam int unsigned GIF_EVW = GIF_PINS * GIF_LANE;
  localparam int unsigned GIF_FRC3_W = 24;
  // Position of each event type inside a pin's group
  localparam int unsigned GIF_BIT_RISE = 3;
  localparam int unsigned GIF_BIT_FALL = 2;
  localparam int unsigned GIF_BIT_HIGH = 1;
  localparam int unsigned GIF_BIT_LOW = 0;
  // Register offsets
  localparam logic [GIF_AW-1:0] GIF_OFF_EN0 = 12'h100;
  localparam logic [GIF_AW-1:0] GIF_OFF_EN1 = 12'h104;
  localparam logic [GIF_AW-1:0] GIF_OFF_EN2 = 12'h108;
  localparam logic [GIF_AW-1:0] GIF_OFF_EN3 = 12'h10c;
  localparam logic [GIF_AW-1:0] GIF_OFF_FRC0 = 12'h110;
  localparam logic [GIF_AW-1:0] GIF_OFF_FRC1 = 12'h114;
  localparam logic [GIF_AW-1:0] GIF_OFF_FRC2 = 12'h118;
  localparam logic [GIF_AW-1:0] GIF_OFF_FRC3 = 12'h11c;
  localparam logic [GIF_AW-1:0] GIF_OFF_STS0 = 12'h120;
  localparam logic [GIF_AW-1:0] GIF_OFF_EVT = 12'h140;
  localparam logic [GIF_AW-1:0] GIF_OFF_EVT_MASK = 12'h144;
  // Reset values
  localparam logic [GIF_DW-1:0] GIF_RST_WORD = 32'h0000_0000;
  localparam logic [GIF_FRC3_W-1:0] GIF_RST_FRC3 = 24'h00_0000;
  localparam logic [GIF_DW-1:0] GIF_FRC3_MASK = 32'h00ff_ffff;
  // Housekeeping event bits
  localparam int unsigned GIF_EV_N = 3;
  localparam int unsigned GIF_EV_IRQ_RISE = 0;
  localparam int unsigned GIF_EV_RSVD_WR = 1;
  localparam int unsigned GIF_EV_UNMAPPED = 2;
  localparam logic [GIF_EV_N-1:0] GIF_RST_EV = 3'h0;

  typedef struct packed {
    logic [GIF_AW-1:0] addr;
    logic [GIF_DW-1:0] wdata;
    logic wr;
    logic rd;
  } gif_bus_req_t;

  typedef logic [GIF_EVW-1:0] gif_evvec_t;
endpackage : gif_pkg
`default_nettype wire

// ===== sim/gif_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import gif_pkg::*;
  logic ref_clk;
  logic srst;
  gif_bus_req_t bus_req;
  logic [GIF_DW-1:0] rdata;
  gif_evvec_t raw_events;
  logic first_core_irq;
  logic house_irq;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;

  gif_core uut (
    .ref_clk(ref_clk),
    .srst(srst),
    .bus_req(bus_req),
    .rdata(rdata),
    .raw_events(raw_events),
    .first_core_irq(first_core_irq),
    .house_irq(house_irq)
  );

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task summarize;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  // Hang guard, far above the roughly 150 cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles >= 3000) begin
      miscompares++;
      summarize;
    end
  end

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Bus tasks start and end just after a rising edge
  task bus_wr(input logic [GIF_AW-1:0] a, input logic [GIF_DW-1:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req <= '0;
    @(posedge ref_clk);
  endtask : bus_wr

  task rchk(input string what, input logic [GIF_AW-1:0] a,
            input logic [GIF_DW-1:0] exp);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req <= '0;
    @(negedge ref_clk);
    chk(what, exp, rdata);
    @(posedge ref_clk);
  endtask : rchk

  // Lets the registered core line follow, then checks both lines
  task irq_chk(input logic core_exp, input logic house_exp);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("first_core_irq", {31'h0, core_exp}, {31'h0, first_core_irq});
    chk("house_irq", {31'h0, house_exp}, {31'h0, house_irq});
    @(posedge ref_clk);
  endtask : irq_chk

  task t_reset;
    rchk("force 8-15 reset", GIF_OFF_FRC1, 32'h0);
    rchk("force 16-23 reset", GIF_OFF_FRC2, 32'h0);
    rchk("force 24-29 reset", GIF_OFF_FRC3, 32'h0);
    rchk("status reset", GIF_OFF_STS0, 32'h0);
    irq_chk(1'b0, 1'b0);
  endtask : t_reset

  task t_force;
    logic [GIF_AW-1:0] offs [3];
    logic [GIF_DW-1:0] vals [3];
    offs = '{GIF_OFF_FRC1, GIF_OFF_FRC2, GIF_OFF_FRC3};
    vals = '{32'ha5a5_5a5a, 32'h8000_0000, 32'h0000_0001};
    for (int i = 0; i < 3; i++) begin
      bus_wr(offs[i], vals[i]);
      rchk("force readback", offs[i], vals[i]);
      irq_chk(1'b1, 1'b0);
      bus_wr(offs[i], 32'h0);
      irq_chk(1'b0, 1'b0);
    end
  endtask : t_force

  task t_reserved;
    bus_wr(GIF_OFF_FRC3, 32'hff00_0000);
    irq_chk(1'b0, 1'b0);
    rchk("force 24-29 top byte", GIF_OFF_FRC3, 32'h0);
    bus_wr(GIF_OFF_FRC3, 32'hffff_ffff);
    rchk("force 24-29 lanes", GIF_OFF_FRC3, GIF_FRC3_MASK);
    bus_wr(GIF_OFF_FRC3, 32'h0);
    bus_wr(GIF_OFF_EVT_MASK, 32'h2);
    irq_chk(1'b0, 1'b1);
    bus_wr(GIF_OFF_EVT, 32'h7);
    irq_chk(1'b0, 1'b0);
    bus_wr(GIF_OFF_EVT_MASK, 32'h4);
    rchk("unmapped read", 12'h200, 32'h0);
    irq_chk(1'b0, 1'b1);
    bus_wr(GIF_OFF_EVT, 32'h7);
    irq_chk(1'b0, 1'b0);
    bus_wr(GIF_OFF_EVT_MASK, 32'h0);
  endtask : t_reserved

  // Line event and its clear in one cycle: the event must win
  task t_set_wins;
    bus_wr(GIF_OFF_EN0, 32'h0000_0001);
    bus_wr(GIF_OFF_EVT, 32'h7);
    raw_events <= {{(GIF_EVW-1){1'b0}}, 1'b1};
    bus_wr(GIF_OFF_EVT, 32'h1);
    rchk("line event beats clear", GIF_OFF_EVT, 32'h1);
    bus_wr(GIF_OFF_EVT, 32'h1);
    rchk("line event cleared", GIF_OFF_EVT, 32'h0);
    raw_events <= '0;
    bus_wr(GIF_OFF_EN0, 32'h0);
    irq_chk(1'b0, 1'b0);
  endtask : t_set_wins

  // Reset in mid-run must clear state set up before it
  task t_mid_reset;
    bus_wr(GIF_OFF_FRC2, 32'hffff_ffff);
    bus_wr(GIF_OFF_EVT_MASK, 32'h1);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    rchk("force 16-23 after reset", GIF_OFF_FRC2, 32'h0);
    rchk("event mask after reset", GIF_OFF_EVT_MASK, 32'h0);
    rchk("status after reset", GIF_OFF_STS0, 32'h0);
    irq_chk(1'b0, 1'b0);
  endtask : t_mid_reset

  task t_status;
    gif_evvec_t ev;
    ev = '0;
    ev[4*7+GIF_BIT_RISE] = 1'b1;
    ev[GIF_BIT_LOW] = 1'b1;
    ev[4+GIF_BIT_LOW] = 1'b1;
    ev[4*20+GIF_BIT_HIGH] = 1'b1;
    bus_wr(GIF_OFF_EN0, 32'h8000_0001);
    raw_events <= ev;
    @(posedge ref_clk);
    rchk("status enabled raw", GIF_OFF_STS0, 32'h8000_0001);
    irq_chk(1'b1, 1'b0);
    bus_wr(GIF_OFF_FRC0, 32'h0000_0010);
    rchk("status forced", GIF_OFF_STS0, 32'h8000_0011);
    bus_wr(GIF_OFF_STS0, 32'hffff_ffff);
    rchk("status after write", GIF_OFF_STS0, 32'h8000_0011);
    bus_wr(GIF_OFF_EN0, 32'h0);
    bus_wr(GIF_OFF_FRC0, 32'h0);
    rchk("status cleared", GIF_OFF_STS0, 32'h0);
    irq_chk(1'b0, 1'b0);
    bus_wr(GIF_OFF_EN2, 32'h0002_0000);
    irq_chk(1'b1, 1'b0);
    bus_wr(GIF_OFF_EN2, 32'h0);
    raw_events <= '0;
    irq_chk(1'b0, 1'b0);
  endtask : t_status

  initial begin
    srst = 1'b1;
    bus_req = '0;
    raw_events = '0;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset;
    t_force;
    t_reserved;
    t_status;
    t_set_wins;
    t_mid_reset;
    summarize;
  end
endmodule : testbench
`default_nettype wire
